// File: hdl/wip_packer.sv
// The register offsets and the Avalon-MM slave port were decided locally.
module wip_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != FULL_CNT);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

module wip_packer #(
  parameter bit FOUR_PORT = 1'b1
) (
  input  wire logic                              clock_i,
  input  wire logic                              resetn_i,
  input  wire logic [4:0]                        avs_address_i,
  input  wire logic                              avs_read_i,
  input  wire logic                              avs_write_i,
  input  wire logic [31:0]                       avs_writedata_i,
  input  wire logic [3:0]                        avs_byteenable_i,
  output logic [31:0]                            avs_readdata_o,
  output logic                                   avs_waitrequest_o,
  input  wire wip_pkg::wip_port_in_t [wip_pkg::NPORTS-1:0] port_in_i,
  input  wire logic [wip_pkg::NCONN-1:0]         pin4_digital_input_i,
  input  wire logic [wip_pkg::NCONN-1:0]         pin2_digital_input_i,
  output logic [wip_pkg::IMG_W-1:0]              in_img_o,
  input  wire logic                              out_img_valid_i,
  output logic                                   out_img_ready_o,
  input  wire logic [wip_pkg::IMG_W-1:0]         out_img_i,
  output wip_pkg::wip_pd_t [wip_pkg::NPORTS-1:0] out_pd_o,
  output logic                                   out_pd_valid_o,
  input  wire logic                              out_pd_ready_i,
  output logic [wip_pkg::NCONN-1:0]              pin4_digital_output_o,
  output logic [wip_pkg::NCONN-1:0]              pin2_digital_output_o,
  output logic                                   aux_power_output_o
);
  localparam int NP = wip_pkg::NPORTS;
  localparam int TW = wip_pkg::TOT_W;

  logic [15:0]                  in_size_reg;
  logic [15:0]                  out_size_reg;
  logic [7:0]                   mode_reg;
  logic                         reject_reg;
  logic                         rd_ack_reg;
  logic [31:0]                  rdata_reg;
  logic [31:0]                  merged_wdata;
  logic [2*wip_pkg::NCONN-1:0]  pin_meta_reg;
  logic [2*wip_pkg::NCONN-1:0]  pin_sync_reg;
  wip_pkg::wip_pd_t             hold_reg [NP];
  logic [wip_pkg::IMG_W-1:0]    in_img_reg;
  logic [TW-1:0]                in_off [NP];
  logic [TW-1:0]                out_off [NP];
  logic [TW-1:0]                in_total;
  logic [TW-1:0]                out_total;
  logic [7:0]                   hdr_n;
  logic [7:0]                   hdr_n1;
  logic [wip_pkg::PD_W-1:0]     pd_bytes;
  logic                         fifo_valid;
  logic [wip_pkg::IMG_W-1:0]    fifo_data;
  logic                         drain;
  logic [15:0]                  size_wdata;
  logic                         size_ok;
  logic                         wr_in_size;
  logic                         wr_out_size;
  logic [31:0]                  rd_mux;

  function automatic logic [TW-1:0] size_sum(input logic [15:0] s);
    logic [TW-1:0] acc;
    acc = '0;
    for (int p = 0; p < NP; p++) begin
      acc = acc + TW'(s[p*wip_pkg::SZ_W +: wip_pkg::SZ_W]);
    end
    return acc;
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------- register bus ----------------
  // reads take one wait cycle so read data comes from a flop
  assign avs_waitrequest_o = avs_read_i && !rd_ack_reg;
  assign avs_readdata_o    = rdata_reg;
  assign wr_in_size  = avs_write_i && (avs_address_i == wip_pkg::REG_IN_SIZE);
  assign wr_out_size = avs_write_i && (avs_address_i == wip_pkg::REG_OUT_SIZE);
  assign merged_wdata = be_merge(wr_in_size ? {16'h0000, in_size_reg}
                                            : {16'h0000, out_size_reg},
                                 avs_writedata_i, avs_byteenable_i);
  assign size_wdata  = merged_wdata[15:0];
  assign size_ok     = (size_sum(size_wdata) <= wip_pkg::PD_LIMIT);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      wip_pkg::REG_IN_SIZE:  rd_mux = {16'h0000, in_size_reg};
      wip_pkg::REG_OUT_SIZE: rd_mux = {16'h0000, out_size_reg};
      wip_pkg::REG_MODE:     rd_mux = {24'h000000, mode_reg};
      wip_pkg::REG_STATUS: begin
        rd_mux[wip_pkg::ST_REJECT]             = reject_reg;
        rd_mux[wip_pkg::ST_IN_TOT +: TW]       = in_total;
        rd_mux[wip_pkg::ST_OUT_TOT +: TW]      = out_total;
      end
      wip_pkg::REG_IMAGE:    rd_mux = {16'h0000, in_img_reg[15:0]};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_ack_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      rd_ack_reg <= avs_read_i && !rd_ack_reg;
      if (avs_read_i && !rd_ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      in_size_reg  <= wip_pkg::SIZE_RST;
      out_size_reg <= wip_pkg::SIZE_RST;
      mode_reg     <= wip_pkg::MODE_RST;
    end else begin
      if (wr_in_size && size_ok) begin
        in_size_reg <= size_wdata;
      end
      if (wr_out_size && size_ok) begin
        out_size_reg <= size_wdata;
      end
      if (avs_write_i && (avs_address_i == wip_pkg::REG_MODE) && avs_byteenable_i[0]) begin
        mode_reg <= avs_writedata_i[7:0];
      end
    end
  end

  // sticky reject flag, write one to clear; a new reject wins over the clear
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      reject_reg <= 1'b0;
    end else if ((wr_in_size || wr_out_size) && !size_ok) begin
      reject_reg <= 1'b1;
    end else if (avs_write_i && (avs_address_i == wip_pkg::REG_STATUS) &&
                 avs_byteenable_i[0] && avs_writedata_i[wip_pkg::ST_REJECT]) begin
      reject_reg <= 1'b0;
    end
  end

  // ---------------- pin input synchroniser ----------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {pin2_digital_input_i, pin4_digital_input_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ---------------- input image ----------------
  always_comb begin
    in_total  = '0;
    out_total = '0;
    for (int p = 0; p < NP; p++) begin
      in_off[p]  = in_total;
      out_off[p] = out_total;
      in_total   = in_total + TW'(in_size_reg[p*wip_pkg::SZ_W +: wip_pkg::SZ_W]);
      out_total  = out_total + TW'(out_size_reg[p*wip_pkg::SZ_W +: wip_pkg::SZ_W]);
    end
  end

  generate
    for (genvar p = 0; p < NP; p++) begin : g_port
      localparam bit PRESENT = FOUR_PORT || (p < wip_pkg::NCONN);
      // flag p sits at bit pair p, so port one owns bits 0 and 1
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          hold_reg[p] <= '0;
        end else if (port_in_i[p].valid) begin
          hold_reg[p] <= port_in_i[p].pd;
        end
      end
      always_comb begin
        hdr_n[2*p+1]  = PRESENT && port_in_i[p].link;
        hdr_n[2*p]    = PRESENT &&
                        (wip_pkg::wip_mode_t'(mode_reg[2*p +: 2]) == wip_pkg::WIP_MODE_DI)
                        && pin_sync_reg[p];
        hdr_n1[2*p+1] = PRESENT && port_in_i[p].event_f;
        hdr_n1[2*p]   = PRESENT && port_in_i[p].valid;
      end
    end
    for (genvar k = 0; k < wip_pkg::PD_BYTES; k++) begin : g_in_byte
      localparam logic [TW-1:0] KB = TW'(k);
      always_comb begin
        logic [TW-1:0] idx;
        idx = '0;
        pd_bytes[k*8 +: 8] = 8'h00;
        for (int p = 0; p < NP; p++) begin
          if (wip_pkg::wip_mode_t'(mode_reg[2*p +: 2]) == wip_pkg::WIP_MODE_IOL &&
              KB >= in_off[p] &&
              KB < in_off[p] + TW'(in_size_reg[p*wip_pkg::SZ_W +: wip_pkg::SZ_W])) begin
            idx = KB - in_off[p];
            pd_bytes[k*8 +: 8] = hold_reg[p][8*idx +: 8];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      in_img_reg <= '0;
    end else begin
      in_img_reg <= {pd_bytes, hdr_n1, hdr_n};
    end
  end
  assign in_img_o = in_img_reg;

  // ---------------- output image ----------------
  // the fifo absorbs radio bursts while the port side stalls
  wip_fifo #(
    .WIDTH (wip_pkg::IMG_W),
    .DEPTH (wip_pkg::FIFO_DEPTH)
  ) u_out_fifo (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (out_img_valid_i),
    .in_ready_o  (out_img_ready_o),
    .in_data_i   (out_img_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (out_pd_ready_i),
    .out_data_o  (fifo_data)
  );
  assign drain = fifo_valid && out_pd_ready_i;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      out_pd_valid_o <= 1'b0;
    end else begin
      out_pd_valid_o <= drain;
    end
  end

  generate
    for (genvar p = 0; p < NP; p++) begin : g_out_port
      for (genvar j = 0; j < wip_pkg::PD_BYTES; j++) begin : g_out_byte
        localparam logic [TW-1:0] JB = TW'(j);
        logic [TW-1:0] src;
        assign src = out_off[p] + JB + TW'(wip_pkg::HDR_BYTES);
        always_ff @(posedge clock_i) begin
          if (!resetn_i) begin
            out_pd_o[p][j*8 +: 8] <= 8'h00;
          end else if (drain) begin
            if (wip_pkg::wip_mode_t'(mode_reg[2*p +: 2]) == wip_pkg::WIP_MODE_IOL &&
                JB < TW'(out_size_reg[p*wip_pkg::SZ_W +: wip_pkg::SZ_W])) begin
              out_pd_o[p][j*8 +: 8] <= fifo_data[8*src +: 8];
            end else begin
              out_pd_o[p][j*8 +: 8] <= 8'h00;
            end
          end
        end
      end
    end
    for (genvar c = 0; c < wip_pkg::NCONN; c++) begin : g_conn
      // byte N+1 of the output image is reserved and never read
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          pin4_digital_output_o[c] <= 1'b0;
          pin2_digital_output_o[c] <= 1'b0;
        end else if (drain) begin
          pin4_digital_output_o[c] <= fifo_data[2*c] &&
            (wip_pkg::wip_mode_t'(mode_reg[2*c +: 2]) == wip_pkg::WIP_MODE_DO);
          pin2_digital_output_o[c] <= FOUR_PORT && fifo_data[wip_pkg::PIN2_BASE + 2*c] &&
            (wip_pkg::wip_mode_t'(mode_reg[2*(c+2) +: 2]) == wip_pkg::WIP_MODE_DO);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      aux_power_output_o <= 1'b0;
    end else if (drain) begin
      aux_power_output_o <= !FOUR_PORT && fifo_data[wip_pkg::AUX_BIT];
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_reset_sizes;
    $rose(resetn_i) |-> in_size_reg == wip_pkg::SIZE_RST && out_size_reg == wip_pkg::SIZE_RST;
  endproperty
  a_reset_sizes: assert property (p_reset_sizes) else $error("sizes not at reset value");

  property p_reject;
    (wr_in_size && !size_ok) |=> reject_reg && in_size_reg == $past(in_size_reg);
  endproperty
  a_reject: assert property (p_reject) else $error("oversize config accepted");

  property p_zero_fill;
    in_total < wip_pkg::PD_LIMIT ##1 $stable(in_size_reg)
      |-> in_img_reg[wip_pkg::IMG_W-8 +: 8] == 8'h00;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("unused image byte not zero");

  property p_link_flag;
    port_in_i[0].link |=> in_img_reg[1];
  endproperty
  a_link_flag: assert property (p_link_flag) else $error("link flag of port one lost");

  property p_valid_flag;
    ##1 in_img_reg[8] == $past(port_in_i[0].valid);
  endproperty
  a_valid_flag: assert property (p_valid_flag) else $error("valid flag misplaced");

  property p_event_flag;
    ##1 in_img_reg[9] == $past(port_in_i[0].event_f);
  endproperty
  a_event_flag: assert property (p_event_flag) else $error("event flag misplaced");

  property p_hold;
    !port_in_i[0].valid |=> hold_reg[0] == $past(hold_reg[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("invalid data overwrote held data");

  property p_di_mask;
    (wip_pkg::wip_mode_t'(mode_reg[1:0]) != wip_pkg::WIP_MODE_DI) |=> !in_img_reg[0];
  endproperty
  a_di_mask: assert property (p_di_mask) else $error("digital input shown outside DI");

  property p_pin4_out;
    drain && wip_pkg::wip_mode_t'(mode_reg[1:0]) == wip_pkg::WIP_MODE_DO
      |=> pin4_digital_output_o[0] == $past(fifo_data[0]);
  endproperty
  a_pin4_out: assert property (p_pin4_out) else $error("pin4 output not from bit 0");

  property p_variant;
    !FOUR_PORT |-> in_img_reg[7:4] == 4'h0 && in_img_reg[15:12] == 4'h0
                   && !pin2_digital_output_o[0];
  endproperty
  a_variant: assert property (p_variant) else $error("two-port upper bits populated");
endmodule

// File: hdl/wip_pkg.sv
package wip_pkg;
  localparam int NPORTS    = 4;
  localparam int NCONN     = 2;
  localparam int IMG_BYTES = 16;
  localparam int HDR_BYTES = 2;
  localparam int PD_BYTES  = 14;
  localparam int IMG_W     = IMG_BYTES * 8;
  localparam int PD_W      = PD_BYTES * 8;
  localparam int SZ_W      = 4;
  localparam int TOT_W     = 6;
  localparam int FIFO_DEPTH = 4;

  localparam logic [TOT_W-1:0] PD_LIMIT = 6'h0E;
  // per-port size nibbles, port one in the low nibble
  localparam logic [15:0] SIZE_RST = 16'h0068;

  typedef enum logic [1:0] {
    WIP_MODE_IOL = 2'h0,
    WIP_MODE_DI  = 2'h1,
    WIP_MODE_DO  = 2'h2
  } wip_mode_t;
  localparam logic [7:0] MODE_RST = 8'h50;

  // avalon byte addresses
  localparam logic [4:0] REG_IN_SIZE  = 5'h00;
  localparam logic [4:0] REG_OUT_SIZE = 5'h04;
  localparam logic [4:0] REG_MODE     = 5'h08;
  localparam logic [4:0] REG_STATUS   = 5'h0C;
  localparam logic [4:0] REG_IMAGE    = 5'h10;

  localparam int ST_REJECT = 0;
  localparam int ST_IN_TOT = 8;
  localparam int ST_OUT_TOT = 16;
  localparam int AUX_BIT   = 7;
  localparam int PIN2_BASE = 4;

  typedef logic [PD_W-1:0] wip_pd_t;

  typedef struct packed {
    wip_pd_t pd;
    logic    valid;
    logic    event_f;
    logic    link;
  } wip_port_in_t;
endpackage

// File: test/wip_base_model.sv
module wip_base_model (
  input  wire logic                 clock_i,
  input  wire logic                 resetn_i,
  input  wire logic                 stall_i,
  input  wire logic                 ready_i,
  output logic                      valid_o,
  output logic [wip_pkg::IMG_W-1:0] img_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [wip_pkg::IMG_W-1:0] pend_q[$];
  logic                      rdy_q;

  task automatic send(input logic [wip_pkg::IMG_W-1:0] img);
    pend_q.push_back({img[127:16], 8'h00, img[7:0]});
  endtask

  initial begin
    valid_o = 1'b0;
    img_o   = '0;
    rdy_q   = 1'b0;
  end

  // ready is combinational: take it before the edge, not in the edge's time step
  always @(negedge clock_i) rdy_q <= ready_i;

  // image held until taken; a released bus shows the inverse, not the old value
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
    end else if (valid_o && rdy_q) begin
      valid_o <= 1'b0;
      img_o   <= ~img_o;
    end else if (!valid_o && pend_q.size() > 0 && !stall_i) begin
      valid_o <= 1'b1;
      img_o   <= pend_q.pop_front();
    end
  end
endmodule

// File: test/test_wip_packer.sv
module test_wip_packer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [447:0] pd;
    logic [1:0]   p4;
    logic [1:0]   p2;
    logic         aux;
  } wip_exp_t;
  logic                        clock_i = 1'b0;
  logic                        resetn_i = 1'b0;
  logic [4:0]                  avs_address_i = '0;
  logic                        avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0]                 avs_writedata_i = '0, avs_readdata_o;
  logic                        avs_waitrequest_o;
  wip_pkg::wip_port_in_t [3:0] port_in_i = '0;
  logic [1:0]                  pin4_in = '0, pin2_in = '0, pin4_out, pin2_out;
  logic [1:0]                  pin4_out2, pin2_out2;
  logic [127:0]                in_img, in_img2, out_img;
  wip_pkg::wip_pd_t [3:0]      out_pd;
  logic                        aux, aux2, out_img_valid, out_img_ready, out_pd_valid;
  logic                        out_pd_ready = 1'b0, stall = 1'b0, hold_rdy = 1'b0;
  logic [15:0]                 isz = 16'h0068, osz = 16'h0068;
  logic [7:0]                  md = 8'h50;
  logic [111:0]                held [4] = '{default: '0};
  logic [15:0]                 sz_tab [6] = '{16'h0068, 16'h2345, 16'h0E00, 16'h1111,
                                              16'hE000, 16'h0707};
  logic [7:0]                  md_tab [6] = '{8'h50, 8'h00, 8'h51, 8'hAA, 8'h0A, 8'hCC};
  wip_exp_t                    exp_q[$];
  wip_exp_t                    cur;
  logic [127:0]                ex;
  int                          seed = 32'h8317;
  int                          failures = 0;
  int                          checks = 0;

  wip_packer #(.FOUR_PORT(1'b1)) dut (
    .clock_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .port_in_i,
    .pin4_digital_input_i(pin4_in), .pin2_digital_input_i(pin2_in), .in_img_o(in_img),
    .out_img_valid_i(out_img_valid), .out_img_ready_o(out_img_ready), .out_img_i(out_img),
    .out_pd_o(out_pd), .out_pd_valid_o(out_pd_valid), .out_pd_ready_i(out_pd_ready),
    .pin4_digital_output_o(pin4_out), .pin2_digital_output_o(pin2_out),
    .aux_power_output_o(aux));
  wip_packer #(.FOUR_PORT(1'b0)) dut2 (
    .clock_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o(), .avs_waitrequest_o(), .port_in_i,
    .pin4_digital_input_i(pin4_in), .pin2_digital_input_i(pin2_in), .in_img_o(in_img2),
    .out_img_valid_i(out_img_valid), .out_img_ready_o(), .out_img_i(out_img),
    .out_pd_o(), .out_pd_valid_o(), .out_pd_ready_i(out_pd_ready),
    .pin4_digital_output_o(pin4_out2), .pin2_digital_output_o(pin2_out2),
    .aux_power_output_o(aux2));
  wip_base_model base (.clock_i, .resetn_i, .stall_i(stall), .ready_i(out_img_ready),
    .valid_o(out_img_valid), .img_o(out_img));

  always #2 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    out_pd_ready <= !hold_rdy && ($random(seed) & 1) != 0;
    stall        <= ($random(seed) & 3) == 0;
  end

  task automatic end_sim();
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [447:0] exp, input logic [447:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    @(posedge clock_i);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 20) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(nm, {416'h0, exp}, {416'h0, q});
  endtask

  function automatic logic [31:0] stat(input logic [15:0] s, input logic rej);
    logic [5:0] t;
    t = s[3:0] + s[7:4] + s[11:8] + s[15:12];
    return {10'h0, t, 2'h0, t, 7'h0, rej};
  endfunction

  function automatic logic [127:0] exp_in(input logic four);
    logic [127:0] r;
    logic [3:0]   di;
    int           off;
    r = '0;
    off = 0;
    di = {pin2_in, pin4_in};
    for (int p = 0; p < 4; p++) begin
      if (p < 2 || four) begin
        r[2*p+1]   = port_in_i[p].link;
        r[2*p]     = di[p] & (md[2*p+:2] == wip_pkg::WIP_MODE_DI);
        r[8+2*p+1] = port_in_i[p].event_f;
        r[8+2*p]   = port_in_i[p].valid;
      end
      for (int b = 0; b < isz[4*p+:4]; b++) begin
        if (md[2*p+:2] == wip_pkg::WIP_MODE_IOL) r[16+8*off+:8] = held[p][8*b+:8];
        off++;
      end
    end
    return r;
  endfunction

  task automatic cfg(input logic [15:0] s, input logic [7:0] m);
    wr(wip_pkg::REG_IN_SIZE, {16'h0, s});
    wr(wip_pkg::REG_OUT_SIZE, {16'h0, s});
    wr(wip_pkg::REG_MODE, {24'h0, m});
    isz = s;
    osz = s;
    md = m;
    rd(wip_pkg::REG_STATUS, stat(s, 1'b0), "status");
  endtask

  task automatic in_step();
    logic [127:0] r;
    logic [127:0] e;
    @(posedge clock_i);
    for (int p = 0; p < 4; p++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      port_in_i[p] <= r[114:0];
      if (r[2]) held[p] = r[114:3];
    end
    {pin4_in, pin2_in} <= r[118:115];
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk("in_img", {320'h0, exp_in(1'b1)}, {320'h0, in_img});
    e = exp_in(1'b0);
    chk("in_status_two", {432'h0, e[15:0]}, {432'h0, in_img2[15:0]});
  endtask

  task automatic out_step();
    logic [127:0] r;
    wip_exp_t     e;
    int           off;
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    r[15:8] = 8'h00;
    e = '0;
    off = 0;
    for (int p = 0; p < 4; p++)
      for (int b = 0; b < osz[4*p+:4]; b++) begin
        if (md[2*p+:2] == wip_pkg::WIP_MODE_IOL) e.pd[112*p+8*b+:8] = r[16+8*off+:8];
        off++;
      end
    for (int c = 0; c < 2; c++) begin
      e.p4[c] = r[2*c] & (md[2*c+:2] == wip_pkg::WIP_MODE_DO);
      e.p2[c] = r[4+2*c] & (md[4+2*c+:2] == wip_pkg::WIP_MODE_DO);
    end
    e.aux = r[7];
    exp_q.push_back(e);
    base.send(r);
  endtask

  task automatic drain_wait();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 500) begin
      failures++;
      end_sim();
    end
  endtask

  always @(negedge clock_i) begin
    if (out_pd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("drain_extra", 448'h0, 448'h1);
      end else begin
        cur = exp_q.pop_front();
        chk("out_pd", cur.pd, out_pd);
        chk("pins", {cur.p4, cur.p2, 1'b0, cur.p4, 2'b00, cur.aux},
            {pin4_out, pin2_out, aux, pin4_out2, pin2_out2, aux2});
      end
    end
  end

  initial begin
    repeat (50000) @(posedge clock_i);
    failures++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rd(wip_pkg::REG_IN_SIZE, 32'h68, "in_size");
    rd(wip_pkg::REG_OUT_SIZE, 32'h68, "out_size");
    rd(wip_pkg::REG_MODE, 32'h50, "mode");
    rd(wip_pkg::REG_STATUS, stat(16'h0068, 1'b0), "status");
    rd(5'h14, 32'h0, "unmapped");
    for (int i = 0; i < 6; i++) begin
      cfg(sz_tab[i], md_tab[i]);
      repeat (3) in_step();
      ex = exp_in(1'b1);
      rd(wip_pkg::REG_IMAGE, {16'h0, ex[15:0]}, "image");
      repeat (4) out_step();
      drain_wait();
    end
    // total of fifteen must be refused and leave the sizes alone
    wr(wip_pkg::REG_IN_SIZE, 32'h0000E001);
    rd(wip_pkg::REG_IN_SIZE, {16'h0, isz}, "in_size_kept");
    rd(wip_pkg::REG_STATUS, stat(isz, 1'b1), "reject_set");
    wr(wip_pkg::REG_STATUS, 32'h1);
    rd(wip_pkg::REG_STATUS, stat(isz, 1'b0), "reject_clr");
    hold_rdy <= 1'b1;
    repeat (6) out_step();
    repeat (40) @(posedge clock_i);
    @(negedge clock_i);
    chk("fifo_full", 448'h0, {447'h0, out_img_ready});
    hold_rdy <= 1'b0;
    drain_wait();
    @(negedge clock_i);
    chk("fifo_empty", 448'h1, {447'h0, out_img_ready});
    end_sim();
  end
endmodule
